// [core/uds_sources.sv]
// usb device interrupt source flags with suspend and resume detection
`timescale 1ns/1ps

module uds_sources
  import uds_pkg::*;
#(
  parameter int unsigned SUSPEND_CYCLES = SUSPEND_CYCLES_DEFAULT
)
(
  input  wire logic                   SYS_CLK,
  input  wire logic                   RST,
  input  wire logic                   USB_MODULE_ENABLE,
  input  wire logic                   RESUME_INTERRUPT_ENABLE,
  input  wire logic [NUM_SOURCES-1:0] SOURCE_MASK,
  input  wire logic [NUM_SOURCES-1:0] FLAG_CLEAR,
  input  wire logic                   EP_ONE_BUF1_READY,
  input  wire logic                   EP_ONE_ERROR,
  input  wire logic                   EP_TWO_BUF0_READY,
  input  wire logic                   EP_TWO_BUF1_READY,
  input  wire logic                   EP_TWO_ERROR,
  input  wire logic                   EP_THREE_BUF0_READY,
  input  wire logic                   EP_THREE_BUF1_READY,
  input  wire logic                   EP_THREE_ERROR,
  input  wire logic                   CTRL_TWO_BUF_READY,
  input  wire logic                   CTRL_TWO_STATUS_STAGE,
  input  wire logic                   CTRL_TWO_SETUP_READY,
  input  wire logic                   CTRL_TWO_ERROR,
  input  wire logic                   IN_TWO_BUF_WRITABLE,
  input  wire logic                   USB_DATA_PLUS,
  input  wire logic                   USB_DATA_MINUS,
  output logic      [NUM_SOURCES-1:0] USB_DEVICE_SOURCE_FLAGS,
  output logic                        USB_DEVICE_REQUEST
);

  //////////////////////////////////////////////////////////////////////////////
  // line state decode

  function automatic uds_bus_e bus_state(input logic dp, input logic dm);
    case ({dp, dm})
      2'b10:   bus_state = UDS_BUS_J;
      2'b01:   bus_state = UDS_BUS_K;
      2'b00:   bus_state = UDS_BUS_SE0;
      default: bus_state = UDS_BUS_SE1;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [1:0] dp_sync_q;
  logic [1:0] dm_sync_q;
  uds_bus_e   line_prev_q;

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      dp_sync_q <= 2'h0;
      dm_sync_q <= 2'h0;
    end
    else
    begin
      dp_sync_q <= {dp_sync_q[0], USB_DATA_PLUS};
      dm_sync_q <= {dm_sync_q[0], USB_DATA_MINUS};
    end
  end

  uds_bus_e line_now;
  logic     line_is_j;
  assign line_now  = bus_state(dp_sync_q[1], dm_sync_q[1]);
  assign line_is_j = (line_now == UDS_BUS_J);

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
      line_prev_q <= UDS_BUS_SE0;
    else
      line_prev_q <= line_now;
  end

  //////////////////////////////////////////////////////////////////////////////
  // suspend: idle J timer, restarts whenever the bus leaves J

  localparam logic [SUSPEND_CNT_W-1:0] SUSPEND_LAST =
    SUSPEND_CNT_W'(SUSPEND_CYCLES - 1);
  localparam logic [SUSPEND_CNT_W-1:0] CNT_ZERO = '0;
  localparam logic [SUSPEND_CNT_W-1:0] CNT_ONE  = SUSPEND_CNT_W'(1);

  logic [SUSPEND_CNT_W-1:0] idle_cnt_q;
  logic [SUSPEND_CNT_W-1:0] idle_cnt_d;
  logic                     idle_done_q;
  logic                     idle_done_d;
  logic                     idle_hit;

  assign idle_hit    = USB_MODULE_ENABLE && line_is_j && !idle_done_q
                       && (idle_cnt_q == SUSPEND_LAST);
  assign idle_cnt_d  = (!USB_MODULE_ENABLE || !line_is_j) ? CNT_ZERO
                       : (idle_done_q ? idle_cnt_q : idle_cnt_q + CNT_ONE);
  // one request per idle period; rearmed once the bus leaves J or the module is disabled
  assign idle_done_d = (USB_MODULE_ENABLE && line_is_j) && (idle_done_q || idle_hit);

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      idle_cnt_q  <= CNT_ZERO;
      idle_done_q <= 1'b0;
    end
    else
    begin
      idle_cnt_q  <= idle_cnt_d;
      idle_done_q <= idle_done_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // resume: J to SE0 or K while both enables set

  logic resume_hit;
  assign resume_hit = USB_MODULE_ENABLE && RESUME_INTERRUPT_ENABLE
                      && (line_prev_q == UDS_BUS_J)
                      && ((line_now == UDS_BUS_SE0) || (line_now == UDS_BUS_K));

  //////////////////////////////////////////////////////////////////////////////
  // per-source set terms

  logic [NUM_SOURCES-1:0] set_vec;
  assign set_vec[SRC_EP_ONE]   = USB_MODULE_ENABLE
                                 && (EP_ONE_BUF1_READY || EP_ONE_ERROR);
  assign set_vec[SRC_EP_TWO]   = USB_MODULE_ENABLE
                                 && (EP_TWO_BUF0_READY || EP_TWO_BUF1_READY
                                     || EP_TWO_ERROR);
  assign set_vec[SRC_EP_THREE] = USB_MODULE_ENABLE
                                 && (EP_THREE_BUF0_READY || EP_THREE_BUF1_READY
                                     || EP_THREE_ERROR);
  assign set_vec[SRC_CTRL_TWO] = USB_MODULE_ENABLE
                                 && (CTRL_TWO_BUF_READY || CTRL_TWO_STATUS_STAGE
                                     || CTRL_TWO_SETUP_READY || CTRL_TWO_ERROR);
  assign set_vec[SRC_IN_TWO]   = USB_MODULE_ENABLE && IN_TWO_BUF_WRITABLE;
  assign set_vec[SRC_SUSPEND]  = idle_hit;
  assign set_vec[SRC_RESUME]   = resume_hit;

  //////////////////////////////////////////////////////////////////////////////
  // sticky flags: set wins over a clear in the same cycle

  logic [NUM_SOURCES-1:0] flags_q;
  logic [NUM_SOURCES-1:0] flags_d;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_SOURCES; gi++)
    begin : g_flag
      assign flags_d[gi] = set_vec[gi] || (flags_q[gi] && !FLAG_CLEAR[gi]);
    end
  endgenerate

  logic request_d;
  assign request_d = |(flags_d & SOURCE_MASK);

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      flags_q            <= FLAGS_RESET;
      USB_DEVICE_REQUEST <= 1'b0;
    end
    else
    begin
      flags_q            <= flags_d;
      USB_DEVICE_REQUEST <= request_d;
    end
  end

  assign USB_DEVICE_SOURCE_FLAGS = flags_q;

endmodule

// [include/uds_pkg.sv]
// constants shared by the usb device interrupt source block
package uds_pkg;

  localparam int unsigned NUM_SOURCES = 7;

  // flag positions
  localparam int unsigned SRC_EP_ONE      = 0;
  localparam int unsigned SRC_EP_TWO      = 1;
  localparam int unsigned SRC_EP_THREE    = 2;
  localparam int unsigned SRC_CTRL_TWO    = 3;
  localparam int unsigned SRC_IN_TWO      = 4;
  localparam int unsigned SRC_SUSPEND     = 5;
  localparam int unsigned SRC_RESUME      = 6;

  localparam logic [NUM_SOURCES-1:0] FLAGS_RESET = 7'h00;

  // suspend idle time, then its cycle count at the system clock rate
  localparam int unsigned SUSPEND_TIME_US = 3000;
  localparam int unsigned CLK_FREQ_MHZ    = 40;
  localparam int unsigned SUSPEND_CYCLES_DEFAULT = SUSPEND_TIME_US * CLK_FREQ_MHZ;
  localparam int unsigned SUSPEND_CNT_W   = 18;

  typedef enum logic [1:0] {
    UDS_BUS_SE0,
    UDS_BUS_J,
    UDS_BUS_K,
    UDS_BUS_SE1
  } uds_bus_e;

endpackage

// [tb/uds_sources_chk.sv]
// port assertions for the usb device interrupt source block
`timescale 1ns/1ps
module uds_sources_chk
  import uds_pkg::*;
#(
  parameter int unsigned SUSPEND_CYCLES = SUSPEND_CYCLES_DEFAULT
)
(
  input wire logic       SYS_CLK,
  input wire logic       RST,
  input wire logic       USB_MODULE_ENABLE,
  input wire logic       RESUME_INTERRUPT_ENABLE,
  input wire logic [6:0] SOURCE_MASK,
  input wire logic [6:0] FLAG_CLEAR,
  input wire logic       EP_TWO_ERROR,
  input wire logic       CTRL_TWO_SETUP_READY,
  input wire logic       IN_TWO_BUF_WRITABLE,
  input wire logic       USB_DATA_PLUS,
  input wire logic       USB_DATA_MINUS,
  input wire logic [6:0] USB_DEVICE_SOURCE_FLAGS,
  input wire logic       USB_DEVICE_REQUEST
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  wire logic [6:0] f = USB_DEVICE_SOURCE_FLAGS;
  wire logic       en = USB_MODULE_ENABLE;
  int unsigned     j_cnt_q;
  // raw pin samples of unbroken idle j while enabled
  always_ff @(posedge SYS_CLK)
  begin
    j_cnt_q <= (RST || !en || !USB_DATA_PLUS || USB_DATA_MINUS) ? 0 : j_cnt_q + 1;
  end
  a_ep_two_set: assert property (EP_TWO_ERROR && en |=> f[1])
    else $error("ep two flag missing");
  a_ctrl_setup_set: assert property (CTRL_TWO_SETUP_READY && en |=> f[3])
    else $error("control flag missing");
  a_in_two_set: assert property (IN_TWO_BUF_WRITABLE && en |=> f[4])
    else $error("in flag missing");
  a_flags_sticky: assert property (1 |=> &(f | $past(FLAG_CLEAR) | ~$past(f)))
    else $error("flag dropped without clear");
  a_request_or: assert property ($stable(SOURCE_MASK) |->
    USB_DEVICE_REQUEST == |(f & SOURCE_MASK))
    else $error("request mismatch");
  a_resume_gated: assert property ($rose(f[6]) |-> $past(en && RESUME_INTERRUPT_ENABLE))
    else $error("resume while disabled");
  a_suspend_early: assert property ($rose(f[5]) |-> j_cnt_q >= SUSPEND_CYCLES)
    else $error("suspend too early");
  a_suspend_due: assert property (j_cnt_q == SUSPEND_CYCLES + 3 |-> f[5])
    else $error("suspend missing");
  c_suspend: cover property ($rose(f[5]));
  c_resume: cover property ($rose(f[6]));
  c_request: cover property ($rose(USB_DEVICE_REQUEST));
endmodule
bind uds_sources uds_sources_chk #(.SUSPEND_CYCLES(SUSPEND_CYCLES)) i_chk (
  .SYS_CLK(SYS_CLK), .RST(RST), .USB_MODULE_ENABLE(USB_MODULE_ENABLE),
  .RESUME_INTERRUPT_ENABLE(RESUME_INTERRUPT_ENABLE), .SOURCE_MASK(SOURCE_MASK),
  .FLAG_CLEAR(FLAG_CLEAR), .EP_TWO_ERROR(EP_TWO_ERROR),
  .CTRL_TWO_SETUP_READY(CTRL_TWO_SETUP_READY), .IN_TWO_BUF_WRITABLE(IN_TWO_BUF_WRITABLE),
  .USB_DATA_PLUS(USB_DATA_PLUS), .USB_DATA_MINUS(USB_DATA_MINUS),
  .USB_DEVICE_SOURCE_FLAGS(USB_DEVICE_SOURCE_FLAGS), .USB_DEVICE_REQUEST(USB_DEVICE_REQUEST));

// [tb/uds_host_model.sv]
// full-speed host model driving the data pair from a bus state
`timescale 1ns/1ps
module uds_host_model
  import uds_pkg::*;
(
  input  wire uds_bus_e bus_state,
  output logic          usb_data_plus,
  output logic          usb_data_minus
);
  assign usb_data_plus  = bus_state inside {UDS_BUS_J, UDS_BUS_SE1};
  assign usb_data_minus = bus_state inside {UDS_BUS_K, UDS_BUS_SE1};
endmodule

// [tb/test_usb_device_interrupt_sources.sv]
// self-checking bench for the usb device interrupt source block
`timescale 1ns/1ps
`define CHK(g, e) \
  begin \
    n_compared++; \
    if ((g) !== (e)) \
    begin \
      failures++; \
      $display("wrong value at %0t: %h %h", $time, (g), (e)); \
    end \
  end
module test_usb_device_interrupt_sources
  import uds_pkg::*;
;
  logic       clk = 0, rst = 1, en = 0, rie = 0, req, dp, dm;
  logic [6:0] mask = 7'h1f, clr = 7'h00, flags;
  logic [12:0] ev = 13'h0000;
  uds_bus_e   bus = UDS_BUS_J;
  int         failures = 0, n_compared = 0, cycles = 0;
  int         src[13] = '{0, 0, 1, 1, 1, 2, 2, 2, 3, 3, 3, 3, 4};
  uds_bus_e   st[2] = '{UDS_BUS_K, UDS_BUS_SE0};
  always #12.5 clk = ~clk;
  uds_host_model i_host (.bus_state(bus), .usb_data_plus(dp), .usb_data_minus(dm));
  uds_sources #(.SUSPEND_CYCLES(20)) i_dut (.SYS_CLK(clk), .RST(rst),
    .USB_MODULE_ENABLE(en), .RESUME_INTERRUPT_ENABLE(rie), .SOURCE_MASK(mask),
    .FLAG_CLEAR(clr), .EP_ONE_BUF1_READY(ev[0]), .EP_ONE_ERROR(ev[1]),
    .EP_TWO_BUF0_READY(ev[2]), .EP_TWO_BUF1_READY(ev[3]), .EP_TWO_ERROR(ev[4]),
    .EP_THREE_BUF0_READY(ev[5]), .EP_THREE_BUF1_READY(ev[6]), .EP_THREE_ERROR(ev[7]),
    .CTRL_TWO_BUF_READY(ev[8]), .CTRL_TWO_STATUS_STAGE(ev[9]),
    .CTRL_TWO_SETUP_READY(ev[10]), .CTRL_TWO_ERROR(ev[11]), .IN_TWO_BUF_WRITABLE(ev[12]),
    .USB_DATA_PLUS(dp), .USB_DATA_MINUS(dm), .USB_DEVICE_SOURCE_FLAGS(flags),
    .USB_DEVICE_REQUEST(req));
  task tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task end_sim;
    if (failures == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      failures++;
      end_sim();
    end
  end
  initial
  begin
    tick(3);
    rst = 0;
    en = 1;
    for (int i = 0; i < 13; i++)
    begin
      ev[i] = 1;
      tick(1);
      ev[i] = 0;
      tick(2);
      `CHK(flags & 7'h1f, 7'h01 << src[i])
      `CHK(req, 1'b1)
      clr = 7'h01 << src[i];
      tick(1);
      clr = 7'h00;
      `CHK(flags & 7'h1f, 7'h00)
      `CHK(req, 1'b0)
    end
    en = 0;
    clr = 7'h60;
    ev[4] = 1;
    tick(1);
    ev[4] = 0;
    clr = 7'h00;
    tick(2);
    `CHK(flags, 7'h00)
    en = 1;
    tick(15);
    bus = UDS_BUS_K;
    tick(1);
    bus = UDS_BUS_J;
    tick(15);
    `CHK(flags, 7'h00)
    tick(10);
    `CHK(flags, 7'h20)
    rie = 1;
    foreach (st[k])
    begin
      clr = 7'h40;
      tick(1);
      clr = 7'h00;
      `CHK(flags[6], 1'b0)
      bus = st[k];
      tick(5);
      `CHK(flags[6], 1'b1)
      bus = UDS_BUS_J;
      tick(3);
    end
    clr = 7'h40;
    en = 0;
    tick(1);
    clr = 7'h00;
    bus = UDS_BUS_K;
    tick(5);
    `CHK(flags[6], 1'b0)
    mask = 7'h00;
    tick(2);
    `CHK(req, 1'b0)
    mask = 7'h20;
    tick(2);
    `CHK(req, 1'b1)
    end_sim();
  end
endmodule
